// File: dv/sap_port_ctrl_bench.sv
// Purpose: Self-checking bench of the serial port control block.
// Assumes: Short bit time; reads and frames are checked against queued notes.
// Notes: The polarity case runs last since it moves the idle line low.
`timescale 1ns/1ns
`default_nettype none
module sap_port_ctrl_bench;
  localparam int BC = 4;
  localparam logic [7:0] C1 = 8'hE0;
  localparam logic [7:0] C2 = 8'hE4;
  localparam logic [7:0] FL = 8'hEC;
  localparam logic [7:0] DT = 8'hF4;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic stopMode = 1'b0;
  logic debugHalt = 1'b0;
  logic [1:0] portBDir = 2'h0;
  logic [1:0] portBData = 2'h3;
  logic sendGo = 1'b0;
  logic [10:0] sendBits = 11'h7FF;
  logic [31:0] avs_readdata, lastRd, m;
  logic avs_waitrequest, rxLine, rxPinOut, rxPinOe, txPinOut, txPinOe, txIrq, rxIrq;
  logic gotValid;
  logic [10:0] gotBits;
  logic [7:0] d;
  logic [31:0] rdExp[$], rdMsk[$];
  logic [10:0] txq[$];
  int bad_count = 0;
  int compares = 0;
  int k;

  always #5 core_clk = ~core_clk;

  sap_port_ctrl #(.BIT_CYCLES(BC)) sap_port_ctrl_i (.core_clk(core_clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stopMode(stopMode),
    .debugHalt(debugHalt), .portBDir(portBDir), .portBData(portBData), .rxPinIn(rxLine),
    .rxPinOut(rxPinOut), .rxPinOe(rxPinOe), .txPinOut(txPinOut), .txPinOe(txPinOe),
    .txIrq(txIrq), .rxIrq(rxIrq));
  sap_remote_node #(.BIT_CYCLES(BC)) sap_remote_node_i (.core_clk(core_clk),
    .sendGo(sendGo), .sendBits(sendBits), .txLine(txPinOut), .rxLine(rxLine),
    .gotValid(gotValid), .gotBits(gotBits));

  task automatic give_verdict();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic fail();
    bad_count++;
    give_verdict();
  endtask

  // One bus access; the request holds until waitrequest is seen low.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dat,
                     input logic [3:0] be, input logic [7:0] e, input logic [7:0] mk);
    int n;
    n = 0;
    if (!w)
    begin
      rdExp.push_back({24'h0, e});
      rdMsk.push_back({24'hFFFFFF, mk});
    end
    avs_address <= a;
    avs_writedata <= {24'h0, dat};
    avs_byteenable <= be;
    avs_read <= !w;
    avs_write <= w;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) fail();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] mk);
    acc(1'b0, a, 8'h00, 4'hF, e, mk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    acc(1'b1, a, dat, 4'hF, 8'h00, 8'h00);
  endtask

  // Bounded poll until a flag bit shows; each poll read also arms the clear.
  task automatic poll(input logic [7:0] mk);
    int n;
    n = 0;
    lastRd = 32'h0;
    while ((lastRd[7:0] & mk) == 8'h00)
    begin
      rd(FL, 8'h00, 8'h00);
      n++;
      if (n > 400) fail();
    end
  endtask

  // Expected line bits of one frame, LSB first, with idle 1 after short frames.
  function automatic logic [10:0] frm(input logic [7:0] x, input logic [2:0] f);
    logic p;
    p = ^x[6:0] ^ (f[2] & x[7]) ^ f[0];
    if (f[2])
      frm = {1'b1, f[1] ? p : 1'b1, x, 1'b0};
    else
      frm = {2'b11, f[1] ? p : x[7], x[6:0], 1'b0};
  endfunction

  task automatic rx_send(input logic [7:0] x);
    sendBits <= frm(x, 3'h0);
    sendGo <= 1'b1;
    @(posedge core_clk);
    sendGo <= 1'b0;
  endtask

  // Each finished read and each captured frame takes the oldest note.
  always @(posedge core_clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      lastRd = avs_readdata;
      m = rdMsk.pop_front();
      check(avs_readdata & m, rdExp.pop_front() & m);
    end
    if (gotValid === 1'b1)
      check({21'h0, gotBits}, {21'h0, txq.size() > 0 ? txq.pop_front() : 11'h7FF});
  end

  initial
  begin
    void'($urandom(32'h0F29));
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    rd(C1, 8'h00, 8'hFF);
    rd(FL, 8'hC0, 8'hFF);
    rd(8'hE8, 8'h00, 8'hFF);
    wr(C2, 8'h0C);
    rd(C2, 8'h00, 8'hFF);
    acc(1'b1, C1, 8'h40, 4'h0, 8'h00, 8'h00);
    rd(C1, 8'h00, 8'hFF);
    wr(C1, 8'h40);
    wr(C2, 8'h0C);
    rd(FL, 8'h00, 8'h40);
    for (k = 0; k < 8; k++)
    begin
      poll(8'h40);
      wr(C1, {3'b010, k[2], 2'b00, k[1:0]});
      d = 8'($urandom());
      rd(FL, 8'h80, 8'h80);
      wr(DT, d);
      txq.push_back(frm(d, k[2:0]));
    end
    poll(8'h40);
    wr(C2, 8'h0D);
    repeat (2 * BC) @(posedge core_clk);
    wr(C2, 8'h0C);
    txq.push_back(11'h000);
    poll(8'h40);
    stopMode <= 1'b1;
    rd(FL, 8'h80, 8'h80);
    wr(DT, 8'hA5);
    repeat (12 * BC) @(posedge core_clk);
    rd(FL, 8'h00, 8'h40);
    txq.push_back(frm(8'hA5, 3'h7));
    stopMode <= 1'b0;
    poll(8'h40);
    wr(C1, 8'hC0);
    d = 8'($urandom());
    rd(FL, 8'h80, 8'h80);
    wr(DT, d);
    rx_send(~d);
    txq.push_back(frm(d, 3'h0));
    poll(8'h20);
    rd(DT, d, 8'hFF);
    poll(8'h40);
    wr(C1, 8'h40);
    wr(C2, 8'h2C);
    rx_send(8'h3C);
    poll(8'h20);
    wr(C2, 8'h28);
    rd(FL, 8'h20, 8'h20);
    wr(C2, 8'h2C);
    debugHalt <= 1'b1;
    rd(DT, 8'h3C, 8'hFF);
    debugHalt <= 1'b0;
    check({31'h0, rxIrq}, 32'h1);
    rd(DT, 8'h3C, 8'hFF);
    check({31'h0, rxIrq}, 32'h0);
    wr(8'hF8, 8'h01);
    rx_send(8'hC3);
    poll(8'h20);
    debugHalt <= 1'b1;
    rd(DT, 8'hC3, 8'hFF);
    debugHalt <= 1'b0;
    check({31'h0, rxIrq}, 32'h0);
    wr(8'hF8, 8'h00);
    wr(C2, 8'h2E);
    repeat (24 * BC) @(posedge core_clk);
    rd(C2, 8'h2C, 8'hFF);
    wr(C2, 8'h8C);
    check({31'h0, txIrq}, 32'h1);
    wr(C2, 8'h0C);
    check({31'h0, txIrq}, 32'h0);
    wr(C2, 8'h4C);
    check({31'h0, txIrq}, 32'h1);
    portBDir <= 2'h1;
    wr(C1, 8'h00);
    check({31'h0, txIrq}, 32'h0);
    rd(FL, 8'hC0, 8'hC0);
    check({29'h0, txPinOe, rxPinOe, rxPinOut}, 32'h3);
    wr(C1, 8'h60);
    check({30'h0, txPinOut, rxPinOe}, 32'h0);
    check({31'h0, txPinOe}, 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire

// File: dv/sap_port_ctrl_checker.sv
// Purpose: Port-level checks of the serial port control block.
// Assumes: Bound to sap_port_ctrl; one clock domain.
// Notes: Register state is hidden here, so pin checks lean on the port-off cases.
`timescale 1ns/1ns
`default_nettype none
module sap_port_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // System and pins
  input wire logic stopMode,
  input wire logic [1:0] portBDir,
  input wire logic [1:0] portBData,
  input wire logic rxPinOut,
  input wire logic rxPinOe,
  input wire logic txPinOut,
  input wire logic txPinOe,
  input wire logic txIrq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // Every access waits exactly one cycle.
  property p_wait_rise;
    $rose(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_rise: assert property (p_wait_rise) else $error("no wait cycle");
  property p_wait_end;
    avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("wait too long");

  // Read data are one byte wide; a hole in the map reads zero.
  property p_rd_high;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("upper read bits set");
  property p_rd_hole;
    avs_read && !avs_waitrequest && avs_address[7:2] == 6'h3A |-> avs_readdata == 32'h0;
  endproperty
  a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");

  // A driven receive pin means the port is off, so both pins fall back.
  property p_off_tx;
    rxPinOe |-> txPinOe == portBDir[1] && txPinOut == portBData[1];
  endproperty
  a_off_tx: assert property (p_off_tx) else $error("tx pin fallback wrong");
  property p_on_rx;
    txPinOe && !portBDir[1] |-> !rxPinOe && !rxPinOut == !portBData[0] || !rxPinOe;
  endproperty
  a_on_rx: assert property (p_on_rx) else $error("rx pin driven while on");

  // Transmit interrupts need the port switched on.
  property p_irq_on;
    txIrq |-> txPinOe && !rxPinOe;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("tx irq while off");

  // A settled stop with no writes freezes the line.
  property p_stop;
    stopMode && $past(stopMode) && $past(stopMode, 2) && !$past(avs_write)
      && $stable(portBData) |-> $stable(txPinOut);
  endproperty
  a_stop: assert property (p_stop) else $error("line moved in stop");
endmodule
bind sap_port_ctrl sap_port_checker sap_port_checker_i (.core_clk, .srst, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .stopMode, .portBDir, .portBData,
  .rxPinOut, .rxPinOe, .txPinOut, .txPinOe, .txIrq);
`default_nettype wire

// File: dv/sap_remote_node.sv
// Purpose: Far serial node; sends frames on rx and captures frames from tx.
// Assumes: Bit time is BIT_CYCLES clocks; the line idles at 1.
// Notes: Capture starts on a falling edge only, so preamble ones pass unseen.
`timescale 1ns/1ns
`default_nettype none
module sap_remote_node #(
  parameter int BIT_CYCLES = 4
) (
  // Clock
  input wire logic core_clk,
  // Frame to send
  input wire logic sendGo,
  input wire logic [10:0] sendBits,
  // Lines
  input wire logic txLine,
  output logic rxLine,
  // Captured frame
  output logic gotValid,
  output logic [10:0] gotBits
);
  int i;
  int j;
  // Frames leave LSB first and end high, so the line idles at 1.
  initial rxLine = 1'b1;
  always @(posedge core_clk)
  begin
    if (sendGo)
    begin
      for (i = 0; i < 11; i++)
      begin
        rxLine <= sendBits[i];
        repeat (BIT_CYCLES) @(posedge core_clk);
      end
    end
  end
  // Eleven mid-bit samples, so a break shows as a run of zeros.
  initial gotValid = 1'b0;
  always
  begin
    @(negedge txLine);
    repeat (BIT_CYCLES / 2) @(posedge core_clk);
    for (j = 0; j < 11; j++)
    begin
      gotBits[j] = txLine;
      repeat (BIT_CYCLES) @(posedge core_clk);
    end
    gotValid <= 1'b1;
    @(posedge core_clk);
    gotValid <= 1'b0;
  end
endmodule
`default_nettype wire

// File: rtl/sap_pkg.sv
// Purpose: Shared constants and types of the serial port control block.
// Assumes: Registers sit on 32-bit Avalon words, byte address is four times the index.
// Notes: Field positions are fixed by the packed register structs below.
package sap_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_CTRL1 = 6'h38;
  localparam logic [5:0] IDX_CTRL2 = 6'h39;
  localparam logic [5:0] IDX_FLAGS1 = 6'h3B;
  localparam logic [5:0] IDX_DATA = 6'h3D;
  localparam logic [5:0] IDX_HALT = 6'h3E;

  // Reset values and the set of flags cleared by a two-step sequence.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'hC0;
  localparam logic [7:0] ARM_MASK = 8'hBB;

  // Frame lengths in bits, start and stop included.
  localparam logic [3:0] LEN_SHORT = 4'hA;
  localparam logic [3:0] LEN_LONG = 4'hB;
  localparam logic [3:0] LEN_MARK = 4'h1;

  // Control register one.
  typedef struct packed {
    logic loopbackSel;
    logic serialOn;
    logic txPolarityFlip;
    logic longFrame;
    logic wakeOnMark;
    logic idleCountOrigin;
    logic parityOn;
    logic parityOddSel;
  } sap_ctrl1_t;

  // Control register two.
  typedef struct packed {
    logic txEmptyIrqOn;
    logic txDoneIrqOn;
    logic rxFullIrqOn;
    logic idleIrqOn;
    logic txOn;
    logic rxOn;
    logic rxStandby;
    logic sendBrk;
  } sap_ctrl2_t;

  // Status flags.
  typedef struct packed {
    logic txEmptyFlag;
    logic txDoneFlag;
    logic rxFullFlag;
    logic idleFlag;
    logic overrunFlag;
    logic rsvd;
    logic framingErrFlag;
    logic parityErrFlag;
  } sap_flags_t;

  // Frame shape handed to the shifter.
  typedef struct packed {
    logic longFrame;
    logic parityOn;
    logic parityOddSel;
  } sap_tx_cfg_t;

  typedef enum logic [2:0] {TXR_NONE, TXR_IDLE, TXR_BRK, TXR_MARK, TXR_DATA} sap_txreq_t;
  typedef enum logic {RX_IDLE, RX_FRAME} sap_rxst_t;

  // Shifter state.
  typedef struct packed {
    logic busy;
    logic line;
    logic [3:0] cnt;
    logic [10:0] shift;
  } sap_tx_state_t;

  // Parity bit over seven or eight data bits; even gives the plain XOR.
  function automatic logic sap_parity(input logic [7:0] d, input logic all8,
                                      input logic odd);
    sap_parity = ^{d[7] & all8, d[6:0]} ^ odd;
  endfunction

endpackage

// File: rtl/sap_port_ctrl.sv
// Purpose: Register file, pin sharing, flags and receive control of the serial port.
// Assumes: Avalon-MM slave with byte addresses; debugHalt and stopMode share core_clk.
// Notes: Every access is answered with one wait cycle; read data come from a flop.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module sap_port_ctrl #(
  parameter int unsigned BIT_CYCLES = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Avalon-MM register slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // System state
  input wire logic stopMode,
  input wire logic debugHalt,
  // Port pin fallback while the serial port is off
  input wire logic [1:0] portBDir,
  input wire logic [1:0] portBData,
  // Pins
  input wire logic rxPinIn,
  output logic rxPinOut,
  output logic rxPinOe,
  output logic txPinOut,
  output logic txPinOe,
  // Interrupt requests
  output logic txIrq,
  output logic rxIrq
);
  // Elaboration check: the bit timer is sixteen bits and needs a half bit of at least one.
  if (BIT_CYCLES < 4 || BIT_CYCLES > 65536)
  begin : gBadBit
    $error("BIT_CYCLES must lie in 4 to 65536");
  end

  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2 - 1);

  // Whole state of the block.
  typedef struct packed {
    sap_pkg::sap_ctrl1_t ctrl1;
    sap_pkg::sap_ctrl2_t ctrl2;
    sap_pkg::sap_flags_t flags;
    sap_pkg::sap_flags_t arm;
    logic haltClrAllow;
    logic [7:0] txData;
    logic [7:0] rxData;
    logic ack;
    logic [7:0] rdData;
    logic preamblePend;
    logic brkSent;
    logic [15:0] baudCnt;
    logic rxSync1;
    logic rxSync2;
    logic rxPrev;
    sap_pkg::sap_rxst_t rxState;
    logic [15:0] rxTimer;
    logic [3:0] rxIdx;
    logic [8:0] rxShift;
    logic [3:0] onesCnt;
    logic idleArm;
  } sap_main_t;

  sap_main_t s;
  sap_main_t n;

  // Combinational helpers.
  logic busReq;
  logic take;
  logic wrLow;
  logic rdTake;
  logic [5:0] idx;
  logic clrOk;
  logic [7:0] readMux;
  logic bitTick;
  logic rxEn;
  logic rxLine;
  logic rxTick;
  logic [3:0] frameLen;
  logic countOne;
  logic zeroOnes;
  logic charDone;
  logic idleEvt;
  logic [8:0] rxChar;
  logic rxMsb;
  logic parBad;
  sap_pkg::sap_txreq_t txReq;
  sap_pkg::sap_tx_cfg_t txCfg;
  logic txAccept;
  logic txBusy;
  logic txSerial;

  // Bus decode: one wait cycle, the access acts on the edge where waitrequest is low.
  assign busReq = avs_read | avs_write;
  assign idx = avs_address[7:2];
  assign take = busReq & s.ack;
  assign wrLow = take & avs_write & avs_byteenable[0];
  assign rdTake = take & avs_read;
  assign avs_waitrequest = busReq & ~s.ack;
  assign avs_readdata = {24'h000000, s.rdData};
  assign clrOk = ~debugHalt | s.haltClrAllow;

  // Read multiplexer; unmapped words read as zero.
  always_comb
  begin
    case (idx)
      sap_pkg::IDX_CTRL1: readMux = s.ctrl1;
      sap_pkg::IDX_CTRL2: readMux = s.ctrl2;
      sap_pkg::IDX_FLAGS1: readMux = s.flags;
      sap_pkg::IDX_DATA: readMux = s.rxData;
      sap_pkg::IDX_HALT: readMux = {7'h00, s.haltClrAllow};
      default: readMux = 8'h00;
    endcase
  end

  // Baud tick and receive path; stop mode freezes both.
  assign bitTick = s.ctrl1.serialOn & ~stopMode & (s.baudCnt == 16'h0000);
  assign rxEn = s.ctrl1.serialOn & s.ctrl2.rxOn & ~stopMode;
  assign rxLine = s.ctrl1.loopbackSel ? txSerial : s.rxSync2;
  assign rxTick = s.rxTimer == 16'h0000;
  assign frameLen = s.ctrl1.longFrame ? sap_pkg::LEN_LONG : sap_pkg::LEN_SHORT;
  assign rxChar = s.ctrl1.longFrame ? s.rxShift : {1'b0, s.rxShift[8:1]};
  assign rxMsb = s.ctrl1.longFrame ? rxChar[8] : rxChar[7];
  assign txCfg = '{s.ctrl1.longFrame, s.ctrl1.parityOn, s.ctrl1.parityOddSel};

  // Parity check against the MSB slot of the received character.
  always_comb
  begin
    if (s.ctrl1.longFrame)
    begin
      parBad = rxChar[8] != sap_pkg::sap_parity(rxChar[7:0], 1'b1, s.ctrl1.parityOddSel);
    end
    else
    begin
      parBad = rxChar[7] != sap_pkg::sap_parity(rxChar[7:0], 1'b0, s.ctrl1.parityOddSel);
    end
  end

  // Transmit request priority: break, then mark after a break, then preamble, then data.
  // Break ahead of preamble is why an early break toggle replaces the preamble.
  always_comb
  begin
    txReq = sap_pkg::TXR_NONE;
    if (s.ctrl1.serialOn & s.ctrl2.txOn & ~stopMode)
    begin
      if (s.ctrl2.sendBrk)
      begin
        txReq = sap_pkg::TXR_BRK;
      end
      else if (s.brkSent)
      begin
        txReq = sap_pkg::TXR_MARK;
      end
      else if (s.preamblePend)
      begin
        txReq = sap_pkg::TXR_IDLE;
      end
      else if (~s.flags.txEmptyFlag)
      begin
        txReq = sap_pkg::TXR_DATA;
      end
    end
  end

  // Next-state logic for bus, flags and receiver.
  always_comb
  begin
    n = s;
    countOne = 1'b0;
    zeroOnes = 1'b0;
    charDone = 1'b0;
    idleEvt = 1'b0;
    // Bus handshake and read data capture.
    n.ack = busReq & ~s.ack;
    if (busReq & ~s.ack & avs_read)
    begin
      n.rdData = readMux;
    end
    // Baud counter runs only while the port is on.
    if (bitTick)
    begin
      n.baudCnt = BIT_LAST;
    end
    else if (s.ctrl1.serialOn & ~stopMode)
    begin
      n.baudCnt = s.baudCnt - 16'h0001;
    end
    // Register writes.
    if (wrLow & idx == sap_pkg::IDX_CTRL1)
    begin
      n.ctrl1 = avs_writedata[7:0];
    end
    if (wrLow & idx == sap_pkg::IDX_CTRL2)
    begin
      n.ctrl2 = avs_writedata[7:0];
      if (~s.ctrl1.serialOn)
      begin
        n.ctrl2.txOn = s.ctrl2.txOn;
        n.ctrl2.rxOn = s.ctrl2.rxOn;
      end
      else if (avs_writedata[3] & ~s.ctrl2.txOn)
      begin
        n.preamblePend = 1'b1;
      end
    end
    if (wrLow & idx == sap_pkg::IDX_HALT)
    begin
      n.haltClrAllow = avs_writedata[0];
    end
    if (wrLow & idx == sap_pkg::IDX_DATA)
    begin
      n.txData = avs_writedata[7:0];
    end
    // First step of a clear arms only the flags the reader was shown, taken from the
    // captured read byte, so a flag that sets during the wait cycle is not armed unseen.
    if (rdTake & idx == sap_pkg::IDX_FLAGS1 & clrOk)
    begin
      n.arm = s.arm | (s.rdData & sap_pkg::ARM_MASK);
    end
    // Second steps: data write clears empty, data read clears armed receive flags.
    if (wrLow & idx == sap_pkg::IDX_DATA & clrOk & s.arm.txEmptyFlag)
    begin
      n.flags.txEmptyFlag = 1'b0;
      n.arm.txEmptyFlag = 1'b0;
    end
    if (rdTake & idx == sap_pkg::IDX_DATA & clrOk)
    begin
      n.flags = n.flags & ~(s.arm & ~8'h80);
      n.arm = n.arm & 8'h80;
    end
    // Transmit hand-off; the set of the empty flag wins over a clear in the same cycle.
    if (txAccept)
    begin
      n.brkSent = txReq == sap_pkg::TXR_BRK;
      if (txReq != sap_pkg::TXR_DATA)
      begin
        n.preamblePend = 1'b0;
      end
      if (txReq == sap_pkg::TXR_DATA)
      begin
        n.flags.txEmptyFlag = 1'b1;
      end
    end
    // Two-flop synchroniser on the receive pin.
    n.rxSync1 = rxPinIn;
    n.rxSync2 = s.rxSync1;
    // Receiver: find the start edge, sample mid-bit, count idle ones.
    if (rxEn)
    begin
      n.rxPrev = rxLine;
      n.rxTimer = rxTick ? BIT_LAST : s.rxTimer - 16'h0001;
      case (s.rxState)
        sap_pkg::RX_IDLE:
        begin
          if (s.rxPrev & ~rxLine)
          begin
            n.rxState = sap_pkg::RX_FRAME;
            n.rxTimer = BIT_HALF;
            n.rxIdx = 4'h0;
          end
          else if (rxTick)
          begin
            countOne = rxLine;
            zeroOnes = ~rxLine;
          end
        end
        sap_pkg::RX_FRAME:
        begin
          if (rxTick)
          begin
            if (s.rxIdx == 4'h0)
            begin
              // A start bit that is high again at mid-bit was a glitch.
              n.rxState = rxLine ? sap_pkg::RX_IDLE : sap_pkg::RX_FRAME;
              n.rxIdx = 4'h1;
              zeroOnes = 1'b1;
            end
            else if (s.rxIdx < frameLen - 4'h1)
            begin
              n.rxShift = {rxLine, s.rxShift[8:1]};
              n.rxIdx = s.rxIdx + 4'h1;
              countOne = rxLine & ~s.ctrl1.idleCountOrigin;
              zeroOnes = ~rxLine | s.ctrl1.idleCountOrigin;
            end
            else
            begin
              n.rxState = sap_pkg::RX_IDLE;
              charDone = 1'b1;
              countOne = rxLine & ~s.ctrl1.idleCountOrigin;
              zeroOnes = ~rxLine | s.ctrl1.idleCountOrigin;
            end
          end
        end
        default:
        begin
          n.rxState = sap_pkg::RX_IDLE;
        end
      endcase
    end
    else if (~stopMode)
    begin
      // Receiver off: reception stops, flags are left as they are.
      n.rxState = sap_pkg::RX_IDLE;
      n.rxPrev = 1'b1;
      n.onesCnt = 4'h0;
    end
    // Idle counter saturates so one idle stretch raises one event.
    if (zeroOnes)
    begin
      n.onesCnt = 4'h0;
    end
    else if (countOne & s.onesCnt < frameLen)
    begin
      n.onesCnt = s.onesCnt + 4'h1;
      idleEvt = s.onesCnt == frameLen - 4'h1;
    end
    // Character end: standby swallows every character except an address mark with wakeOnMark set.
    if (charDone & (~s.ctrl2.rxStandby | (s.ctrl1.wakeOnMark & rxMsb)))
    begin
      if (s.ctrl2.rxStandby)
      begin
        n.ctrl2.rxStandby = 1'b0;
      end
      if (s.flags.rxFullFlag)
      begin
        n.flags.overrunFlag = 1'b1;
      end
      else
      begin
        n.rxData = rxChar[7:0];
        n.flags.framingErrFlag = ~rxLine;
        n.flags.parityErrFlag = s.ctrl1.parityOn & parBad;
      end
      n.flags.rxFullFlag = 1'b1;
      n.idleArm = 1'b1;
    end
    // Idle line: wakes from standby without a flag when wakeOnMark is clear; outside standby sets idle once per character.
    if (idleEvt)
    begin
      if (s.ctrl2.rxStandby & ~s.ctrl1.wakeOnMark)
      begin
        n.ctrl2.rxStandby = 1'b0;
      end
      else if (~s.ctrl2.rxStandby & s.idleArm)
      begin
        n.flags.idleFlag = 1'b1;
        n.idleArm = 1'b0;
      end
    end
    // Done follows empty with nothing on or waiting for the line.
    n.flags.txDoneFlag = n.flags.txEmptyFlag & ~txBusy & ~txAccept &
                         ~n.preamblePend & ~s.ctrl2.sendBrk & ~n.brkSent;
    if (~n.ctrl1.serialOn)
    begin
      n.flags.txEmptyFlag = 1'b1;
      n.flags.txDoneFlag = 1'b1;
    end
    // Stop mode holds everything except the bus and the synchroniser.
    if (stopMode)
    begin
      n.rxState = s.rxState;
      n.rxTimer = s.rxTimer;
      n.onesCnt = s.onesCnt;
      n.rxPrev = s.rxPrev;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s <= '0;
      s.ctrl1 <= sap_pkg::CTRL_RST;
      s.ctrl2 <= sap_pkg::CTRL_RST;
      s.flags <= sap_pkg::FLAGS_RST;
      s.rxSync1 <= 1'b1;
      s.rxSync2 <= 1'b1;
      s.rxPrev <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  // Transmit shifter.
  sap_tx_shift uTx (
    .core_clk(core_clk),
    .srst(srst),
    .bitTick(bitTick),
    .cfg(txCfg),
    .req(txReq),
    .data(s.txData),
    .accept(txAccept),
    .busy(txBusy),
    .serialOut(txSerial)
  );

  // Pin sharing: the port owns both pins while on; inversion covers every level.
  assign txPinOe = s.ctrl1.serialOn | portBDir[1];
  assign txPinOut = s.ctrl1.serialOn ? txSerial ^ s.ctrl1.txPolarityFlip : portBData[1];
  assign rxPinOe = ~s.ctrl1.serialOn & portBDir[0];
  assign rxPinOut = portBData[0];

  // Interrupt requests; standby masks the receiver side.
  assign txIrq = s.ctrl1.serialOn & ((s.flags.txEmptyFlag & s.ctrl2.txEmptyIrqOn) |
                 (s.flags.txDoneFlag & s.ctrl2.txDoneIrqOn));
  assign rxIrq = ~s.ctrl2.rxStandby & ((s.flags.rxFullFlag & s.ctrl2.rxFullIrqOn) |
                 (s.flags.idleFlag & s.ctrl2.idleIrqOn));
endmodule
`default_nettype wire

// File: rtl/sap_tx_shift.sv
// Purpose: Transmit shifter that sends data, preamble, break and mark frames.
// Assumes: bitTick is a one-cycle pulse once per bit time.
// Notes: A new frame loads on the tick that ends the last one, so frames abut.
`timescale 1ns/1ns
`default_nettype none
module sap_tx_shift (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Bit timing and frame shape
  input wire logic bitTick,
  input wire sap_pkg::sap_tx_cfg_t cfg,
  // Frame request
  input wire sap_pkg::sap_txreq_t req,
  input wire logic [7:0] data,
  output logic accept,
  // Line
  output logic busy,
  output logic serialOut
);
  sap_pkg::sap_tx_state_t s;
  sap_pkg::sap_tx_state_t n;
  logic [10:0] frame;
  logic [3:0] len;
  logic ninth;
  logic bit7;

  // Build the frame LSB first, then shift one bit per tick.
  always_comb
  begin
    n = s;
    accept = 1'b0;
    ninth = cfg.parityOn ? sap_pkg::sap_parity(data, 1'b1, cfg.parityOddSel) : 1'b1;
    bit7 = cfg.parityOn ? sap_pkg::sap_parity(data, 1'b0, cfg.parityOddSel) : data[7];
    len = cfg.longFrame ? sap_pkg::LEN_LONG : sap_pkg::LEN_SHORT;
    frame = 11'h7FF;
    case (req)
      sap_pkg::TXR_DATA:
      begin
        frame = cfg.longFrame ? {1'b1, ninth, data, 1'b0} : {2'b11, bit7, data[6:0], 1'b0};
      end
      sap_pkg::TXR_BRK:
      begin
        frame = 11'h000;
      end
      sap_pkg::TXR_MARK:
      begin
        len = sap_pkg::LEN_MARK;
      end
      default:
      begin
        frame = 11'h7FF;
      end
    endcase
    if (bitTick)
    begin
      if (s.cnt == 4'h0)
      begin
        if (req != sap_pkg::TXR_NONE)
        begin
          accept = 1'b1;
          n.busy = 1'b1;
          n.line = frame[0];
          n.shift = {1'b1, frame[10:1]};
          n.cnt = len - 4'h1;
        end
        else
        begin
          // An unloaded line rests at mark.
          n.busy = 1'b0;
          n.line = 1'b1;
        end
      end
      else
      begin
        n.line = s.shift[0];
        n.shift = {1'b1, s.shift[10:1]};
        n.cnt = s.cnt - 4'h1;
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s <= '0;
      s.line <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  assign busy = s.busy;
  assign serialOut = s.line;
endmodule
`default_nettype wire
